// ### verilog/irq_status_pkg.sv
// Constants for the analog system interrupt status block.
// Assumes a single 100 MHz clock and a plain word-wide register port.

package irq_status_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CLR_OFFSET = 8'h14;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;
	localparam logic [7:0] MASK_OFFSET = 8'h28;

	// ==========================================================
	// Field positions
	localparam int unsigned NUM_EVENTS = 22;
	localparam int unsigned BIT_PHW_HI = 21;
	localparam int unsigned BIT_PHW_LO = 20;
	localparam int unsigned BIT_PHV_HI = 19;
	localparam int unsigned BIT_PHV_LO = 18;
	localparam int unsigned BIT_PHU_HI = 17;
	localparam int unsigned BIT_PHU_LO = 16;
	localparam int unsigned BIT_ESM = 15;
	localparam int unsigned BIT_REF5_OVL = 14;
	localparam int unsigned BIT_REF5_OV = 13;
	localparam int unsigned BIT_REF5_UV = 12;
	localparam int unsigned BIT_BG_OV = 11;
	localparam int unsigned BIT_BG_UV = 10;
	localparam int unsigned BIT_SYS_OT = 9;
	localparam int unsigned BIT_SYS_OTW = 8;
	localparam int unsigned BIT_REG_OT = 7;
	localparam int unsigned BIT_REG_OTW = 6;
	localparam int unsigned BIT_LIN_TMO = 2;
	localparam int unsigned BIT_LIN_OT = 1;
	localparam int unsigned BIT_LIN_OC = 0;

	// Implemented bits: 21..6 and 2..0; 5..3 reserved
	localparam logic [31:0] IMPL_MASK = 32'h003F_FFC7;

	// ==========================================================
	// Reset values
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// ### verilog/flag_cell.sv
// One sticky interrupt status flag with edge-detected event input.
// Assumes the event input is already synchronised to clk_i.

`timescale 1ns/1ns
`default_nettype none

module flag_cell (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic event_i,
	input wire logic clear_i,
	output logic flag_o
);

	// ==========================================================
	// Edge detection
	logic event_q;
	logic flag_q;

	// Previous event level, to catch rising edges only
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			event_q <= 1'b0;
		end else begin
			event_q <= event_i;
		end
	end

	// Sticky flag; a new edge beats a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else if (event_i && !event_q) begin
			flag_q <= 1'b1;
		end else if (clear_i) begin
			flag_q <= 1'b0;
		end
	end

	assign flag_o = flag_q;

endmodule

`default_nettype wire

// ### verilog/analog_system_irq_status.sv
// Analog system interrupt status collector with clear, mask and irq output.
// Assumes event inputs come from other clock domains or pins; each is
// synchronised here. Register port is word-wide with read data one cycle later.
//
// Added by the designer: the address map and the plain strobed port.

`timescale 1ns/1ns
`default_nettype none

module analog_system_irq_status (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_rst_i,
	// Event sources from the analog modules
	input wire logic phase_w_zero_cross_high_irq_i,
	input wire logic phase_w_zero_cross_low_irq_i,
	input wire logic phase_v_zero_cross_high_irq_i,
	input wire logic phase_v_zero_cross_low_irq_i,
	input wire logic phase_u_zero_cross_high_irq_i,
	input wire logic phase_u_zero_cross_low_irq_i,
	input wire logic adc_b_exceptional_seq_irq_i,
	input wire logic ref_5v_overload_irq_i,
	input wire logic ref_5v_overvoltage_irq_i,
	input wire logic ref_5v_undervoltage_irq_i,
	input wire logic bandgap_ref_overvoltage_irq_i,
	input wire logic bandgap_ref_undervoltage_irq_i,
	input wire logic system_overtemp_shutdown_irq_i,
	input wire logic system_overtemp_prewarn_irq_i,
	input wire logic regulator_overtemp_shutdown_irq_i,
	input wire logic regulator_overtemp_prewarn_irq_i,
	input wire logic lin_txd_timeout_irq_i,
	input wire logic lin_overtemp_irq_i,
	input wire logic lin_overcurrent_irq_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Interrupt
	output logic irq_o
);

	// ==========================================================
	// Event gathering
	logic [31:0] raw_events;
	logic [31:0] sync1_q;
	logic [31:0] sync2_q;

	// Pack sources onto their status positions
	always_comb begin
		raw_events = irq_status_pkg::READ_ZERO;
		raw_events[irq_status_pkg::BIT_PHW_HI] = phase_w_zero_cross_high_irq_i;
		raw_events[irq_status_pkg::BIT_PHW_LO] = phase_w_zero_cross_low_irq_i;
		raw_events[irq_status_pkg::BIT_PHV_HI] = phase_v_zero_cross_high_irq_i;
		raw_events[irq_status_pkg::BIT_PHV_LO] = phase_v_zero_cross_low_irq_i;
		raw_events[irq_status_pkg::BIT_PHU_HI] = phase_u_zero_cross_high_irq_i;
		raw_events[irq_status_pkg::BIT_PHU_LO] = phase_u_zero_cross_low_irq_i;
		raw_events[irq_status_pkg::BIT_ESM] = adc_b_exceptional_seq_irq_i;
		raw_events[irq_status_pkg::BIT_REF5_OVL] = ref_5v_overload_irq_i;
		raw_events[irq_status_pkg::BIT_REF5_OV] = ref_5v_overvoltage_irq_i;
		raw_events[irq_status_pkg::BIT_REF5_UV] = ref_5v_undervoltage_irq_i;
		raw_events[irq_status_pkg::BIT_BG_OV] = bandgap_ref_overvoltage_irq_i;
		raw_events[irq_status_pkg::BIT_BG_UV] = bandgap_ref_undervoltage_irq_i;
		raw_events[irq_status_pkg::BIT_SYS_OT] = system_overtemp_shutdown_irq_i;
		raw_events[irq_status_pkg::BIT_SYS_OTW] = system_overtemp_prewarn_irq_i;
		raw_events[irq_status_pkg::BIT_REG_OT] = regulator_overtemp_shutdown_irq_i;
		raw_events[irq_status_pkg::BIT_REG_OTW] = regulator_overtemp_prewarn_irq_i;
		raw_events[irq_status_pkg::BIT_LIN_TMO] = lin_txd_timeout_irq_i;
		raw_events[irq_status_pkg::BIT_LIN_OT] = lin_overtemp_irq_i;
		raw_events[irq_status_pkg::BIT_LIN_OC] = lin_overcurrent_irq_i;
	end

	// Two-stage synchroniser; sources live in analog or other domains
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= irq_status_pkg::READ_ZERO;
			sync2_q <= irq_status_pkg::READ_ZERO;
		end else begin
			sync1_q <= raw_events;
			sync2_q <= sync1_q;
		end
	end

	// ==========================================================
	// Register decode
	logic wr_clr;
	logic wr_mask;
	logic rd_status;
	logic rd_mask;

	// Word-wide strobes only; no byte lanes exist on this port
	assign wr_clr = wr_i && (addr_i == irq_status_pkg::CLR_OFFSET);
	assign wr_mask = wr_i && (addr_i == irq_status_pkg::MASK_OFFSET);
	assign rd_status = rd_i && (addr_i == irq_status_pkg::STATUS_OFFSET);
	assign rd_mask = rd_i && (addr_i == irq_status_pkg::MASK_OFFSET);

	// ==========================================================
	// Clear path on its own reset
	logic [31:0] clr_pulse_q;

	// Clear strobe registered in the clear reset domain, self-clearing
	always_ff @(posedge clk_i or posedge clr_rst_i) begin
		if (clr_rst_i) begin
			clr_pulse_q <= irq_status_pkg::READ_ZERO;
		end else if (wr_clr) begin
			clr_pulse_q <= wdata_i & irq_status_pkg::IMPL_MASK;
		end else begin
			clr_pulse_q <= irq_status_pkg::READ_ZERO;
		end
	end

	// ==========================================================
	// Status flags
	logic [31:0] status;

	// Reserved positions are tied low, so they read zero and ignore writes
	assign status[31:22] = 10'h000;
	assign status[5:3] = 3'h0;

	// ==========================================================
	// Zero-crossing flags, one sticky cell per comparator edge

	// Phase W, comparator high side
	flag_cell w_high_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_PHW_HI]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_PHW_HI]),
		.flag_o(status[irq_status_pkg::BIT_PHW_HI])
	);

	// Phase W, comparator low side
	flag_cell w_low_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_PHW_LO]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_PHW_LO]),
		.flag_o(status[irq_status_pkg::BIT_PHW_LO])
	);

	// Phase V, comparator high side
	flag_cell v_high_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_PHV_HI]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_PHV_HI]),
		.flag_o(status[irq_status_pkg::BIT_PHV_HI])
	);

	// Phase V, comparator low side
	flag_cell v_low_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_PHV_LO]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_PHV_LO]),
		.flag_o(status[irq_status_pkg::BIT_PHV_LO])
	);

	// Phase U, comparator high side
	flag_cell u_high_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_PHU_HI]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_PHU_HI]),
		.flag_o(status[irq_status_pkg::BIT_PHU_HI])
	);

	// Phase U, comparator low side
	flag_cell u_low_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_PHU_LO]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_PHU_LO]),
		.flag_o(status[irq_status_pkg::BIT_PHU_LO])
	);

	// ==========================================================
	// Converter and reference flags

	// Exceptional sequence result; edge only, a held request sets once
	flag_cell esm_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_ESM]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_ESM]),
		.flag_o(status[irq_status_pkg::BIT_ESM])
	);

	// Five volt reference overload
	flag_cell ref_ovl_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_REF5_OVL]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_REF5_OVL]),
		.flag_o(status[irq_status_pkg::BIT_REF5_OVL])
	);

	// First converter reference above its upper threshold
	flag_cell ref_ov_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_REF5_OV]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_REF5_OV]),
		.flag_o(status[irq_status_pkg::BIT_REF5_OV])
	);

	// First converter reference below its lower threshold
	flag_cell ref_uv_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_REF5_UV]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_REF5_UV]),
		.flag_o(status[irq_status_pkg::BIT_REF5_UV])
	);

	// Second converter's own reference too high
	flag_cell bg_ov_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_BG_OV]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_BG_OV]),
		.flag_o(status[irq_status_pkg::BIT_BG_OV])
	);

	// Second converter's own reference too low
	flag_cell bg_uv_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_BG_UV]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_BG_UV]),
		.flag_o(status[irq_status_pkg::BIT_BG_UV])
	);

	// ==========================================================
	// Temperature flags

	// System shutdown level; software must still clear it after cooling
	flag_cell sys_ot_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_SYS_OT]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_SYS_OT]),
		.flag_o(status[irq_status_pkg::BIT_SYS_OT])
	);

	// System prewarning level
	flag_cell sys_otw_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_SYS_OTW]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_SYS_OTW]),
		.flag_o(status[irq_status_pkg::BIT_SYS_OTW])
	);

	// Regulator shutdown level
	flag_cell reg_ot_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_REG_OT]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_REG_OT]),
		.flag_o(status[irq_status_pkg::BIT_REG_OT])
	);

	// Regulator prewarning level
	flag_cell reg_otw_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_REG_OTW]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_REG_OTW]),
		.flag_o(status[irq_status_pkg::BIT_REG_OTW])
	);

	// ==========================================================
	// LIN transceiver flags

	// Transmit data stuck dominant too long
	flag_cell lin_tmo_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_LIN_TMO]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_LIN_TMO]),
		.flag_o(status[irq_status_pkg::BIT_LIN_TMO])
	);

	// Transceiver overtemperature
	flag_cell lin_ot_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_LIN_OT]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_LIN_OT]),
		.flag_o(status[irq_status_pkg::BIT_LIN_OT])
	);

	// Transceiver overcurrent
	flag_cell lin_oc_cell (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(sync2_q[irq_status_pkg::BIT_LIN_OC]),
		.clear_i(clr_pulse_q[irq_status_pkg::BIT_LIN_OC]),
		.flag_o(status[irq_status_pkg::BIT_LIN_OC])
	);

	// ==========================================================
	// Mask register
	logic [31:0] mask_q;

	// Enables gate flags onto the interrupt line
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_q <= irq_status_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= wdata_i & irq_status_pkg::IMPL_MASK;
		end
	end

	// ==========================================================
	// Read data and interrupt
	logic [31:0] rdata_q;
	logic irq_q;

	// Read data one cycle after strobe, zero otherwise; writes to status ignored
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= irq_status_pkg::READ_ZERO;
		end else if (rd_status) begin
			rdata_q <= status;
		end else if (rd_mask) begin
			rdata_q <= mask_q;
		end else begin
			rdata_q <= irq_status_pkg::READ_ZERO;
		end
	end

	// Registered level; one cycle behind the flags, glitch-free
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status & mask_q);
		end
	end

	assign rdata_o = rdata_q;
	assign irq_o = irq_q;

endmodule

`default_nettype wire

// ### testbench/irq_status_checker.sv
// Port-level checker for the analog system interrupt status block.
// Assumes one clock and read data answering one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module irq_status_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic phase_w_zero_cross_high_irq_i,
	input wire logic lin_overcurrent_irq_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic irq_o
);
	localparam logic [7:0] ST = irq_status_pkg::STATUS_OFFSET;
	localparam logic [7:0] CL = irq_status_pkg::CLR_OFFSET;
	localparam logic [7:0] MK = irq_status_pkg::MASK_OFFSET;
	// ==========================================================
	// Assertions, all in the single clock domain
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_rdata_quiet: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0000_0000) else $error("read data outside answer");
	chk_reserved_zero: assert property (
		rdata_o[5:3] == 3'h0 && rdata_o[31:22] == 10'h000) else $error("reserved bits set");
	chk_clear_reads_zero: assert property (
		rd_i && addr_i == CL |=> rdata_o == 32'h0000_0000) else $error("clear reg read nonzero");
	// Input must stay quiet around the clear, or a fresh edge would win
	chk_lin_oc_sets: assert property (
		$rose(lin_overcurrent_irq_i) ##0 (!wr_i)[*5] ##0 (rd_i && addr_i == ST) |=> rdata_o[0])
		else $error("overcurrent flag not set");
	chk_phase_w_sets: assert property (
		$rose(phase_w_zero_cross_high_irq_i) ##0 (!wr_i)[*5] ##0 (rd_i && addr_i == ST)
		|=> rdata_o[21]) else $error("phase w high flag not set");
	chk_clear_takes: assert property (
		(!lin_overcurrent_irq_i)[*3] ##1 (!lin_overcurrent_irq_i && wr_i && addr_i == CL
		&& wdata_i[0]) ##1 (!lin_overcurrent_irq_i)[*3] ##0 (rd_i && addr_i == ST)
		|=> !rdata_o[0]) else $error("cleared flag still reads one");
	chk_mask_readback: assert property (
		wr_i && addr_i == MK ##1 (rd_i && addr_i == MK)
		|=> rdata_o == ($past(wdata_i, 2) & irq_status_pkg::IMPL_MASK))
		else $error("mask readback wrong");
	chk_irq_gated: assert property (
		wr_i && addr_i == MK && wdata_i == 32'h0000_0000 |-> ##2 !irq_o)
		else $error("irq high with mask cleared");
endmodule
bind analog_system_irq_status irq_status_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.phase_w_zero_cross_high_irq_i(phase_w_zero_cross_high_irq_i),
	.lin_overcurrent_irq_i(lin_overcurrent_irq_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the analog system interrupt status block.
// Assumes the checker binds itself; the bench drives every port directly.
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam logic [7:0] ST = irq_status_pkg::STATUS_OFFSET;
	localparam logic [7:0] CL = irq_status_pkg::CLR_OFFSET;
	localparam logic [7:0] MK = irq_status_pkg::MASK_OFFSET;
	localparam logic [31:0] IM = irq_status_pkg::IMPL_MASK;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clr_rst_i = 1'b1;
	logic [21:0] ev = 22'h00_0000;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic irq_o;
	logic [31:0] last, lf, exp_st, exp_mk;
	logic irq_seen;
	int fail_count = 0;
	int checks_done = 0;
	// ==========================================================
	// Clock and design; event vector is indexed by status bit
	always #5 clk_i = ~clk_i;
	analog_system_irq_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .clr_rst_i(clr_rst_i),
		.phase_w_zero_cross_high_irq_i(ev[21]), .phase_w_zero_cross_low_irq_i(ev[20]),
		.phase_v_zero_cross_high_irq_i(ev[19]), .phase_v_zero_cross_low_irq_i(ev[18]),
		.phase_u_zero_cross_high_irq_i(ev[17]), .phase_u_zero_cross_low_irq_i(ev[16]),
		.adc_b_exceptional_seq_irq_i(ev[15]), .ref_5v_overload_irq_i(ev[14]),
		.ref_5v_overvoltage_irq_i(ev[13]), .ref_5v_undervoltage_irq_i(ev[12]),
		.bandgap_ref_overvoltage_irq_i(ev[11]), .bandgap_ref_undervoltage_irq_i(ev[10]),
		.system_overtemp_shutdown_irq_i(ev[9]), .system_overtemp_prewarn_irq_i(ev[8]),
		.regulator_overtemp_shutdown_irq_i(ev[7]), .regulator_overtemp_prewarn_irq_i(ev[6]),
		.lin_txd_timeout_irq_i(ev[2]), .lin_overtemp_irq_i(ev[1]),
		.lin_overcurrent_irq_i(ev[0]), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
	// ==========================================================
	// Helpers; outputs are sampled at the falling edge, away from updates
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
		@(negedge clk_i);
		last = rdata_o;
		irq_seen = irq_o;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a);
		cyc(1'b0, 1'b1, a, 32'h0000_0000);
		cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000);
	endtask
	// Only rising inputs set flags; four idle cycles cover the sync delay
	task automatic events(input logic [21:0] v);
		exp_st = exp_st | ({10'h000, v & ~ev} & IM);
		ev <= v;
		repeat (4) cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000);
	endtask
	task automatic clr(input logic [31:0] c);
		cyc(1'b1, 1'b0, CL, c);
		exp_st = exp_st & ~c;
		repeat (2) cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic cmp_irq(input logic got, input logic want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		end_of_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		lf = 32'h0000_3548;
		exp_st = 32'h0000_0000;
		exp_mk = 32'h0000_0000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		clr_rst_i <= 1'b0;
		rd(ST);
		cmp(last, 32'h0000_0000);
		rd(8'h3C);
		cmp(last, 32'h0000_0000);
		events(IM[21:0]);
		cyc(1'b1, 1'b0, ST, 32'h0000_0000);
		rd(ST);
		cmp(last, IM);
		// Clear register is write-only, even with every flag pending
		rd(CL);
		cmp(last, 32'h0000_0000);
		events(22'h00_0000);
		clr(32'hFFFF_FFFF);
		rd(ST);
		cmp(last, 32'h0000_0000);
		// Each source alone, so a swapped bit shows
		for (int b = 0; b < 22; b++) begin
			if (IM[b]) begin
				events(22'(1) << b);
				rd(ST);
				cmp(last, exp_st);
				events(22'h00_0000);
				clr(32'h0000_0001 << b);
			end
		end
		for (int n = 0; n < 40; n++) begin
			lf = nxt(lf);
			events(lf[21:0]);
			lf = nxt(lf);
			cyc(1'b1, 1'b0, MK, lf);
			exp_mk = lf & IM;
			rd(MK);
			cmp(last, exp_mk);
			cmp_irq(irq_seen, |(exp_st & exp_mk));
			lf = nxt(lf);
			cyc(1'b1, 1'b0, ST, lf);
			clr(nxt(lf));
			rd(ST);
			cmp(last, exp_st);
		end
		// Clear path held in its own reset swallows a clear; flags stay
		clr_rst_i <= 1'b1;
		cyc(1'b1, 1'b0, CL, 32'hFFFF_FFFF);
		clr_rst_i <= 1'b0;
		rd(ST);
		cmp(last, exp_st);
		cyc(1'b1, 1'b0, MK, 32'h0000_0000);
		rd(MK);
		cmp_irq(irq_seen, 1'b0);
		events(22'h00_0000);
		rst_i <= 1'b1;
		cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		rst_i <= 1'b0;
		rd(ST);
		cmp(last, 32'h0000_0000);
		end_of_test();
	end
endmodule
`default_nettype wire
